//--- core/cptm_pkg.sv
// Purpose: Shared constants for the compact timer block
// Assumes: 32-bit AXI4-Lite register bus, byte-wide registers in low bits
// Notes: Offsets are byte addresses of aligned words
package cptm_pkg;
  localparam int unsigned CPTM_AW = 5;
  localparam logic [4:0] CPTM_OFF_CTRL0 = 5'h00;
  localparam logic [4:0] CPTM_OFF_CTRL1 = 5'h04;
  localparam logic [4:0] CPTM_OFF_CNT_LO = 5'h08;
  localparam logic [4:0] CPTM_OFF_CNT_HI = 5'h0c;
  localparam logic [4:0] CPTM_OFF_CMPA_LO = 5'h10;
  localparam logic [4:0] CPTM_OFF_CMPA_HI = 5'h14;
  localparam logic [4:0] CPTM_OFF_INT_STAT = 5'h18;
  localparam logic [4:0] CPTM_OFF_INT_MASK = 5'h1c;
  // Control 0 fields
  localparam int unsigned CPTM_C0_PAUSE = 7;
  localparam int unsigned CPTM_C0_CKSEL_LSB = 4;
  localparam int unsigned CPTM_C0_ON = 3;
  localparam int unsigned CPTM_C0_PVAL_LSB = 0;
  // Control 1 fields
  localparam int unsigned CPTM_C1_MODE_LSB = 6;
  localparam int unsigned CPTM_C1_IO_LSB = 4;
  localparam int unsigned CPTM_C1_OC = 3;
  localparam int unsigned CPTM_C1_POL = 2;
  localparam int unsigned CPTM_C1_DPX = 1;
  localparam int unsigned CPTM_C1_CCLR = 0;
  // Interrupt bits
  localparam int unsigned CPTM_INT_A = 0;
  localparam int unsigned CPTM_INT_P = 1;
  localparam logic [7:0] CPTM_CTRL_RST = 8'h00;
  localparam logic [9:0] CPTM_CNT_RST = 10'h000;
  localparam logic [7:0] CPTM_BYTE_RST = 8'h00;
  localparam logic [1:0] CPTM_INT_RST = 2'h0;
  // Counter clock selections
  localparam logic [2:0] CPTM_CK_SYS4 = 3'h0;
  localparam logic [2:0] CPTM_CK_SYS = 3'h1;
  localparam logic [2:0] CPTM_CK_FH16 = 3'h2;
  localparam logic [2:0] CPTM_CK_FH64 = 3'h3;
  localparam logic [2:0] CPTM_CK_SUB0 = 3'h4;
  localparam logic [2:0] CPTM_CK_SUB1 = 3'h5;
  localparam logic [2:0] CPTM_CK_EXT_RISE = 3'h6;
  localparam logic [2:0] CPTM_CK_EXT_FALL = 3'h7;
  // Operating modes
  localparam logic [1:0] CPTM_MODE_CMP = 2'h0;
  localparam logic [1:0] CPTM_MODE_PWM = 2'h2;
  localparam logic [1:0] CPTM_MODE_TMR = 2'h3;
  // Output function codes
  localparam logic [1:0] CPTM_IO_NONE = 2'h0;
  localparam logic [1:0] CPTM_IO_LOW = 2'h1;
  localparam logic [1:0] CPTM_IO_HIGH = 2'h2;
  localparam logic [1:0] CPTM_IO_TOGGLE = 2'h3;
  localparam logic [1:0] CPTM_PWM_INACT = 2'h0;
  localparam logic [1:0] CPTM_PWM_ACT = 2'h1;
  localparam logic [1:0] CPTM_PWM_RUN = 2'h2;
  // Prescaler wrap values
  localparam logic [1:0] CPTM_DIV4_LAST = 2'h3;
  localparam logic [3:0] CPTM_DIV16_LAST = 4'hf;
  localparam logic [5:0] CPTM_DIV64_LAST = 6'h3f;
  localparam logic [6:0] CPTM_P_LOW_ZERO = 7'h00;
  localparam logic [1:0] CPTM_RESP_OKAY = 2'h0;
  localparam logic [1:0] CPTM_RESP_SLVERR = 2'h2;
endpackage

//--- core/cptm_timer.sv
// Purpose: Compact timer with two comparators, two outputs and AXI4-Lite registers
// Assumes: Single system clock; clock inputs other than clk are sampled as levels
// Notes: Sixteen-bit style pairs share one low-byte buffer; access order matters
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cptm_timer
  import cptm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_count_clock_pin,
  input wire logic internal_high_clock,
  input wire logic sub_clock,
  output logic timer_out_pin,
  output logic timer_out_pin_second,
  output logic irq
);
  // Register state
  logic [7:0] ctrl0_r;
  logic [7:0] ctrl1_r;
  logic [9:0] cnt_r;
  logic [9:0] cmpa_r;
  logic [7:0] lo_buf_r;
  logic [1:0] int_stat_r;
  logic [1:0] int_mask_r;
  logic on_d_r;
  logic out_raw_r;

  // Two-flop synchronisers plus one edge stage for each outside clock
  logic [2:0] ext_sync_r;
  logic [2:0] hclk_sync_r;
  logic [2:0] sub_sync_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_sync_r <= 3'h0;
      hclk_sync_r <= 3'h0;
      sub_sync_r <= 3'h0;
    end else begin
      ext_sync_r <= {ext_sync_r[1:0], ext_count_clock_pin};
      hclk_sync_r <= {hclk_sync_r[1:0], internal_high_clock};
      sub_sync_r <= {sub_sync_r[1:0], sub_clock};
    end
  end
  wire ext_rise = ext_sync_r[1] & ~ext_sync_r[2];
  wire ext_fall = ~ext_sync_r[1] & ext_sync_r[2];
  wire hclk_rise = hclk_sync_r[1] & ~hclk_sync_r[2];
  wire sub_rise = sub_sync_r[1] & ~sub_sync_r[2];

  // Prescalers
  logic [1:0] sys_div_r;
  logic [5:0] hclk_div_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_div_r <= 2'h0;
      hclk_div_r <= 6'h00;
    end else begin
      sys_div_r <= sys_div_r + 2'h1;
      if (hclk_rise) begin
        hclk_div_r <= hclk_div_r + 6'h01;
      end
    end
  end

  // Counter clock selection
  wire [2:0] cksel = ctrl0_r[CPTM_C0_CKSEL_LSB +: 3];
  logic src_tick;
  always_comb begin
    case (cksel)
      CPTM_CK_SYS4: src_tick = (sys_div_r == CPTM_DIV4_LAST);
      CPTM_CK_SYS: src_tick = 1'b1;
      CPTM_CK_FH16: src_tick = hclk_rise & (hclk_div_r[3:0] == CPTM_DIV16_LAST);
      CPTM_CK_FH64: src_tick = hclk_rise & (hclk_div_r == CPTM_DIV64_LAST);
      CPTM_CK_SUB0: src_tick = sub_rise;
      CPTM_CK_SUB1: src_tick = sub_rise;
      CPTM_CK_EXT_RISE: src_tick = ext_rise;
      CPTM_CK_EXT_FALL: src_tick = ext_fall;
      default: src_tick = 1'b0;
    endcase
  end

  // Control field decode
  wire cnt_on = ctrl0_r[CPTM_C0_ON];
  wire cnt_pause = ctrl0_r[CPTM_C0_PAUSE];
  wire [2:0] compare_p_value = ctrl0_r[CPTM_C0_PVAL_LSB +: 3];
  wire [1:0] mode = ctrl1_r[CPTM_C1_MODE_LSB +: 2];
  wire [1:0] iosel = ctrl1_r[CPTM_C1_IO_LSB +: 2];
  wire oc = ctrl1_r[CPTM_C1_OC];
  wire pol = ctrl1_r[CPTM_C1_POL];
  wire dpx = ctrl1_r[CPTM_C1_DPX];
  wire cclr = ctrl1_r[CPTM_C1_CCLR];
  wire on_rise = cnt_on & ~on_d_r;
  wire is_pwm = (mode == CPTM_MODE_PWM);

  // A match fires when the counter reaches the A value; P fires at a 128-count boundary.
  // With P at zero the boundary is the wrap itself, which makes it the overflow match.
  wire tick = src_tick & cnt_on & ~cnt_pause;
  wire [9:0] cnt_inc = cnt_r + 10'h001;
  wire match_a = tick & (cnt_inc == cmpa_r);
  wire match_p = tick & (cnt_inc == {compare_p_value, CPTM_P_LOW_ZERO});
  // PWM picks the period comparator from dpx; other modes use the clear-select bit
  wire clr_on_a = is_pwm ? dpx : cclr;
  wire cnt_clear = clr_on_a ? match_a : match_p;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= CPTM_CNT_RST;
      on_d_r <= 1'b0;
    end else begin
      on_d_r <= cnt_on;
      if (on_rise) begin
        cnt_r <= CPTM_CNT_RST;
      end else if (cnt_clear) begin
        cnt_r <= CPTM_CNT_RST;
      end else if (tick) begin
        cnt_r <= cnt_inc;
      end
    end
  end

  // PWM duty compare: A sets duty in normal form, P bits set it when A is period
  wire pwm_active = dpx ? (cnt_r[9:7] < compare_p_value) : (cnt_r < cmpa_r);
  logic out_nxt;
  always_comb begin
    out_nxt = out_raw_r;
    if (on_rise && mode != CPTM_MODE_TMR) begin
      out_nxt = oc;
    end else if (mode == CPTM_MODE_CMP) begin
      if (match_a) begin
        case (iosel)
          CPTM_IO_NONE: out_nxt = out_raw_r;
          CPTM_IO_LOW: out_nxt = 1'b0;
          CPTM_IO_HIGH: out_nxt = 1'b1;
          CPTM_IO_TOGGLE: out_nxt = ~out_raw_r;
          default: out_nxt = out_raw_r;
        endcase
      end
    end else if (is_pwm) begin
      case (iosel)
        CPTM_PWM_INACT: out_nxt = ~oc;
        CPTM_PWM_ACT: out_nxt = oc;
        CPTM_PWM_RUN: out_nxt = pwm_active ? oc : ~oc;
        default: out_nxt = out_raw_r;
      endcase
    end
  end

  // Second pin is the complement so a pair can drive a bridge
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_raw_r <= 1'b0;
      timer_out_pin <= 1'b0;
      timer_out_pin_second <= 1'b1;
    end else begin
      out_raw_r <= out_nxt;
      timer_out_pin <= out_nxt ^ pol;
      timer_out_pin_second <= ~(out_nxt ^ pol);
    end
  end

  // AXI4-Lite write channel: address and data are held independently
  logic aw_full_r;
  logic w_full_r;
  logic [4:0] aw_addr_r;
  logic [7:0] w_byte_r;
  logic w_lane_r;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_do = aw_full_r & w_full_r & ~s_axi_bvalid;
  wire wr_en = wr_do & w_lane_r;
  wire wr_hit = (aw_addr_r == CPTM_OFF_CTRL0) | (aw_addr_r == CPTM_OFF_CTRL1) |
                (aw_addr_r == CPTM_OFF_CNT_LO) | (aw_addr_r == CPTM_OFF_CNT_HI) |
                (aw_addr_r == CPTM_OFF_CMPA_LO) | (aw_addr_r == CPTM_OFF_CMPA_HI) |
                (aw_addr_r == CPTM_OFF_INT_STAT) | (aw_addr_r == CPTM_OFF_INT_MASK);
  wire wr_ctrl0 = wr_en & (aw_addr_r == CPTM_OFF_CTRL0);
  wire wr_ctrl1 = wr_en & (aw_addr_r == CPTM_OFF_CTRL1);
  wire wr_alo = wr_en & (aw_addr_r == CPTM_OFF_CMPA_LO);
  wire wr_ahi = wr_en & (aw_addr_r == CPTM_OFF_CMPA_HI);
  wire wr_stat = wr_en & (aw_addr_r == CPTM_OFF_INT_STAT);
  wire wr_mask = wr_en & (aw_addr_r == CPTM_OFF_INT_MASK);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= CPTM_OFF_CTRL0;
      w_byte_r <= CPTM_BYTE_RST;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CPTM_RESP_OKAY;
    end else begin
      if (aw_take) begin
        aw_full_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[4:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_full_r <= 1'b1;
        w_byte_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? CPTM_RESP_OKAY : CPTM_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // AXI4-Lite read channel, one read under way at a time
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire [4:0] ar_addr = {s_axi_araddr[4:2], 2'b00};
  wire rd_chi = ar_take & (ar_addr == CPTM_OFF_CNT_HI);
  wire rd_ahi = ar_take & (ar_addr == CPTM_OFF_CMPA_HI);
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    case (ar_addr)
      CPTM_OFF_CTRL0: rd_byte = ctrl0_r;
      CPTM_OFF_CTRL1: rd_byte = ctrl1_r;
      CPTM_OFF_CNT_LO: rd_byte = lo_buf_r;
      CPTM_OFF_CNT_HI: rd_byte = {6'h00, cnt_r[9:8]};
      CPTM_OFF_CMPA_LO: rd_byte = lo_buf_r;
      CPTM_OFF_CMPA_HI: rd_byte = {6'h00, cmpa_r[9:8]};
      CPTM_OFF_INT_STAT: rd_byte = {6'h00, int_stat_r};
      CPTM_OFF_INT_MASK: rd_byte = {6'h00, int_mask_r};
      default: begin
        rd_byte = CPTM_BYTE_RST;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CPTM_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_byte};
        s_axi_rresp <= rd_hit ? CPTM_RESP_OKAY : CPTM_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Shared low-byte buffer. A high read and a low write in one cycle cannot
  // both be honoured; the read wins, as out-of-order access is undefined anyway.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lo_buf_r <= CPTM_BYTE_RST;
    end else if (rd_chi) begin
      lo_buf_r <= cnt_r[7:0];
    end else if (rd_ahi) begin
      lo_buf_r <= cmpa_r[7:0];
    end else if (wr_alo) begin
      lo_buf_r <= w_byte_r;
    end
  end

  // Control and compare registers; counter registers are read only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl0_r <= CPTM_CTRL_RST;
      ctrl1_r <= CPTM_CTRL_RST;
      cmpa_r <= CPTM_CNT_RST;
      int_mask_r <= CPTM_INT_RST;
    end else begin
      if (wr_ctrl0) begin
        ctrl0_r <= w_byte_r;
      end
      if (wr_ctrl1) begin
        ctrl1_r <= w_byte_r;
      end
      if (wr_ahi) begin
        cmpa_r <= {w_byte_r[1:0], lo_buf_r};
      end
      if (wr_mask) begin
        int_mask_r <= w_byte_r[1:0];
      end
    end
  end

  // Sticky match flags: a new match wins over a write-one clear in the same cycle
  wire [1:0] int_set = {match_p, match_a};
  wire [1:0] int_clr = wr_stat ? w_byte_r[1:0] : 2'h0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      int_stat_r <= CPTM_INT_RST;
      irq <= 1'b0;
    end else begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_set;
      irq <= |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
    end
  end

endmodule
`default_nettype wire

//--- verif/cptm_timer_asserts.sv
// Purpose: Port checks for the compact timer
// Assumes: Sees only the ports of cptm_timer
// Notes: Bound below the module
`timescale 1ns/1ps
`default_nettype none
module cptm_asserts
  import cptm_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic timer_out_pin,
  input wire logic timer_out_pin_second
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved while waiting");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
  a_write_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  a_byte_lane: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data above byte lane");
  a_high_width: assert property (
    rd_take ##0 (s_axi_araddr[4:2] inside {3'h3, 3'h5}) |=> s_axi_rdata[7:2] == 6'h0)
    else $error("high byte wider than two bits");
  a_resp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == CPTM_RESP_OKAY)
    else $error("read response not okay");
  a_pin_pair: assert property (timer_out_pin_second == !timer_out_pin)
    else $error("output pins not complementary");
endmodule
bind cptm_timer cptm_asserts cptm_asserts_i (
  .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .timer_out_pin(timer_out_pin),
  .timer_out_pin_second(timer_out_pin_second)
);
`default_nettype wire

//--- verif/compact_timer_module_tb.sv
// Purpose: Self-checking bench for the compact timer
// Assumes: 10 MHz clock, registers over AXI4-Lite
// Notes: High and sub clocks are slow toggles made here
`timescale 1ns/1ps
`default_nettype none
module compact_timer_module_tb;
  import cptm_pkg::*;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, ext, hclk, subclk, pin, pin2, irq;
  logic [4:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, sdiv;
  int fails, check_count;

  cptm_timer cptm_timer_i (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .ext_count_clock_pin(ext), .internal_high_clock(hclk), .sub_clock(subclk),
    .timer_out_pin(pin), .timer_out_pin_second(pin2), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // High clock at half, sub clock at an eighth of the system rate
  always @(posedge clk) begin
    hclk <= ~hclk;
    sdiv <= sdiv + 2'h1;
    if (sdiv == 2'h3) subclk <= ~subclk;
  end

  task automatic check(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    check({6'h0, bresp}, {6'h0, CPTM_RESP_OKAY});
    if (n >= 40) check(8'h1, 8'h0);
  endtask

  // Ready is raised one cycle late so the held answer is exercised
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (arready !== 1'b1 && n < 40);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      n++;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b1;
    @(posedge clk);
    d = rdata[7:0];
    check({6'h0, rresp}, {6'h0, CPTM_RESP_OKAY});
    rready <= 1'b0;
    if (n >= 40) check(8'h1, 8'h0);
  endtask

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    check({7'h0, irq}, 8'h01);
  endtask

  task automatic t_reset;
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      rd(5'(i * 4), d);
      check(d, CPTM_BYTE_RST);
    end
    $display("reset test done");
  endtask

  task automatic t_buffer;
    logic [7:0] d;
    wr(CPTM_OFF_CMPA_LO, 8'h5a);
    wr(CPTM_OFF_CMPA_HI, 8'h03);
    wr(CPTM_OFF_CMPA_LO, 8'h11);
    rd(CPTM_OFF_CMPA_HI, d);
    check(d, 8'h03);
    rd(CPTM_OFF_CMPA_LO, d);
    check(d, 8'h5a);
    rd(CPTM_OFF_CNT_HI, d);
    check(d, 8'h00);
    rd(CPTM_OFF_CMPA_LO, d);
    check(d, 8'h00);
    $display("buffer test done");
  endtask

  task automatic t_compare;
    logic [7:0] d;
    logic oc;
    logic [3:0] exp_pin;
    exp_pin = 4'b0101;
    for (int io = 0; io < 4; io++) begin
      oc = (io != 2);
      wr(CPTM_OFF_CTRL0, 8'h00);
      wr(CPTM_OFF_CMPA_LO, 8'h14);
      wr(CPTM_OFF_CMPA_HI, 8'h00);
      wr(CPTM_OFF_CTRL1, {2'b00, 2'(io), oc, 3'b000});
      wr(CPTM_OFF_INT_MASK, 8'h01);
      wr(CPTM_OFF_CTRL0, 8'h18);
      repeat (2) @(posedge clk);
      check({7'h0, pin}, {7'h0, oc});
      wait_irq(60);
      repeat (2) @(posedge clk);
      check({7'h0, pin}, {7'h0, exp_pin[io]});
      rd(CPTM_OFF_INT_STAT, d);
      check(d, 8'h01);
      wr(CPTM_OFF_INT_STAT, 8'h01);
      repeat (2) @(posedge clk);
      check({7'h0, irq}, 8'h00);
    end
    $display("compare test done");
  endtask

  task automatic t_period;
    logic [7:0] d;
    wr(CPTM_OFF_CTRL0, 8'h00);
    wr(CPTM_OFF_CTRL1, 8'hc0);
    wr(CPTM_OFF_CMPA_LO, 8'hff);
    wr(CPTM_OFF_CMPA_HI, 8'h03);
    wr(CPTM_OFF_INT_MASK, 8'h02);
    wr(CPTM_OFF_CTRL0, 8'h19);
    wait_irq(160);
    rd(CPTM_OFF_INT_STAT, d);
    check(d, 8'h02);
    rd(CPTM_OFF_CNT_HI, d);
    check(d, 8'h00);
    wr(CPTM_OFF_INT_MASK, 8'h00);
    wr(CPTM_OFF_INT_STAT, 8'h02);
    repeat (140) @(posedge clk);
    check({7'h0, irq}, 8'h00);
    rd(CPTM_OFF_INT_STAT, d);
    check(d, 8'h02);
    wr(CPTM_OFF_INT_STAT, 8'h02);
    $display("period test done");
  endtask

  // Any two whole periods of 128 hold exactly twice the duty
  task automatic t_pwm;
    int hi;
    hi = 0;
    wr(CPTM_OFF_CTRL0, 8'h00);
    wr(CPTM_OFF_CMPA_LO, 8'h20);
    wr(CPTM_OFF_CMPA_HI, 8'h00);
    wr(CPTM_OFF_CTRL1, 8'ha8);
    wr(CPTM_OFF_CTRL0, 8'h19);
    repeat (20) @(posedge clk);
    repeat (256) begin
      @(posedge clk);
      hi += int'(pin === 1'b1);
    end
    check(8'(hi), 8'd64);
    $display("pwm test done");
  endtask

  // Period from A (256), duty from P (128), inverted pin; then the fixed levels
  task automatic t_pwm_dpx;
    int hi;
    hi = 0;
    wr(CPTM_OFF_CTRL0, 8'h00);
    wr(CPTM_OFF_CMPA_LO, 8'h00);
    wr(CPTM_OFF_CMPA_HI, 8'h01);
    wr(CPTM_OFF_CTRL1, 8'hae);
    wr(CPTM_OFF_CTRL0, 8'h19);
    repeat (20) @(posedge clk);
    repeat (256) begin
      @(posedge clk);
      hi += int'(pin === 1'b1);
    end
    check(8'(hi), 8'd128);
    wr(CPTM_OFF_CTRL1, 8'h88);
    repeat (2) @(posedge clk);
    check({7'h0, pin}, 8'h00);
    wr(CPTM_OFF_CTRL1, 8'h98);
    repeat (2) @(posedge clk);
    check({7'h0, pin}, 8'h01);
    $display("pwm period test done");
  endtask

  // Nine toggles from low give five rising and four falling edges
  task automatic t_ext;
    logic [7:0] d;
    logic [2:0] sel;
    wr(CPTM_OFF_CTRL1, 8'hc0);
    for (int k = 0; k < 2; k++) begin
      sel = k ? CPTM_CK_EXT_FALL : CPTM_CK_EXT_RISE;
      ext <= 1'b0;
      wr(CPTM_OFF_CTRL0, 8'h00);
      wr(CPTM_OFF_CTRL0, {1'b0, sel, 4'h8});
      for (int j = 0; j < 9; j++) begin
        repeat (4) @(posedge clk);
        ext <= ~ext;
      end
      repeat (6) @(posedge clk);
      wr(CPTM_OFF_CTRL0, {1'b1, sel, 4'h8});
      rd(CPTM_OFF_CNT_HI, d);
      rd(CPTM_OFF_CNT_LO, d);
      check(d, k ? 8'h04 : 8'h05);
    end
    $display("external clock test done");
  endtask

  // Prescaler phase and synchroniser delay allow a small spread
  task automatic t_clksel;
    logic [7:0] d;
    logic [2:0] sels [5];
    logic [7:0] exps [5];
    sels = '{CPTM_CK_SYS4, CPTM_CK_FH16, CPTM_CK_FH64, CPTM_CK_SUB0, CPTM_CK_SUB1};
    exps = '{8'd65, 8'd8, 8'd2, 8'd32, 8'd32};
    for (int k = 0; k < 5; k++) begin
      wr(CPTM_OFF_CTRL0, 8'h00);
      wr(CPTM_OFF_CTRL0, {1'b0, sels[k], 4'h8});
      repeat (256) @(posedge clk);
      wr(CPTM_OFF_CTRL0, {1'b1, sels[k], 4'h8});
      rd(CPTM_OFF_CNT_HI, d);
      rd(CPTM_OFF_CNT_LO, d);
      check({7'h0, d + 8'd2 >= exps[k] && d <= exps[k] + 8'd2}, 8'h01);
    end
    $display("clock select test done");
  endtask

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, ext, hclk, subclk} = 8'h00;
    awaddr = 5'h00;
    araddr = 5'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    sdiv = 2'h0;
    fails = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_buffer;
    t_compare;
    t_period;
    t_pwm;
    t_pwm_dpx;
    t_ext;
    t_clksel;
    end_of_test;
  end

  // About seven times the expected run
  initial begin
    #(100 * 20000);
    check(8'h1, 8'h0);
    end_of_test;
  end
endmodule
`default_nettype wire
